/* operation_code_lines_pkg.sv */
// Package of constants for the operation code responder
package operation_code_lines_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int CODE_W = 5;
    localparam logic [4:0] OP_FETCH = 5'h00;
    localparam logic [4:0] OP_BRANCH = 5'h01;
    localparam logic [4:0] OP_DREAD = 5'h02;
    localparam logic [4:0] OP_IMM = 5'h03;
    localparam logic [4:0] OP_RESTORE = 5'h04;
    localparam logic [4:0] OP_DWRITE = 5'h05;
    localparam logic [4:0] OP_DC_HI = 5'h06;
    localparam logic [4:0] OP_PCB_HI = 5'h07;
    localparam logic [4:0] OP_CALL0 = 5'h08;
    localparam logic [4:0] OP_DC_LO = 5'h09;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] DC_RESET = 16'h0000;
    localparam logic [15:0] ONE16 = 16'h0001;
    localparam int HI_LSB = 8;
    localparam int SIGN_BIT = 7;
endpackage : operation_code_lines_pkg

/* operation_code_lines_mem.sv */
// Byte memory with registered read data
module operation_code_lines_mem #(
    parameter int ABITS = 10
) (
    // Clock
    input wire logic clk,
    // Access
    input wire logic [ABITS-1:0] raddr,
    output logic [7:0] rdata,
    input wire logic we,
    input wire logic [ABITS-1:0] waddr,
    input wire logic [7:0] wdata
);
    logic [7:0] mem [0:(1<<ABITS)-1];
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : operation_code_lines_mem

/* operation_code_lines_responder.sv */
// Memory-side responder following the processor operation code lines
// Overview of operation
// - Cycle ends and next begins at the rising end of the cycle strobe.
// - Five command lines give thirty-two codes; all five are decoded.
// - Code stable through cycle; one operation per cycle.
// - High line reads as one; line four is most significant.
// - Device addresses memory from its own program and data counters.
// - One backup counter holds a copy paired with the program counter; the data counter has none.
// - Every counter-modifying code is applied so all copies stay identical.
// - Bus driven or stored only when selected counter is in own range.
// - Code 00 drives opcode at program counter, then increments it.
// - Code 02 drives byte at data counter, then increments data counter.
// - Code 03 fetches immediate operand exactly like code 00.
// - Code 04 copies backup program counter into program counter.
// - Code 05 writes bus byte at data counter, then increments it.
// - Code 06 drives upper byte of data counter.
// - Code 07 drives upper byte of backup program counter.
// - All logic runs from the processor's clock.
module operation_code_lines_responder #(
    parameter int MEM_ABITS = 10,
    parameter logic [15:0] BASE_ADDR = 16'h0000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Processor control
    input wire logic cycle_strobe,
    input wire logic [operation_code_lines_pkg::CODE_W-1:0] operation_code_lines,
    // Data bus
    input wire logic [operation_code_lines_pkg::DATA_W-1:0] bus_value,
    output logic [operation_code_lines_pkg::DATA_W-1:0] bus_drive,
    output logic db_oe,
    // Counter observation
    output logic [operation_code_lines_pkg::ADDR_W-1:0] program_counter,
    output logic [operation_code_lines_pkg::ADDR_W-1:0] program_counter_backup,
    output logic [operation_code_lines_pkg::ADDR_W-1:0] data_counter
);
    // Elaboration check of the memory size
    if (MEM_ABITS < 1 || MEM_ABITS > 15) begin : g_bad_abits
        $error("MEM_ABITS out of range");
    end

    logic [15:0] pc_reg, pc_next, pcb_reg, pcb_next, dc_reg, dc_next;
    logic strobe_q;
    logic [7:0] drive_reg, drive_next;
    logic oe_reg, oe_next;
    logic [7:0] mem_rdata;

    // Cycle boundary on strobe rising edge
    wire cycle_end = cycle_strobe && !strobe_q;
    wire in_cycle = !cycle_strobe;
    // Full five-bit decode, line 4 most significant
    wire [4:0] code = operation_code_lines;
    wire op_fetch = (code == operation_code_lines_pkg::OP_FETCH) || (code == operation_code_lines_pkg::OP_IMM);
    wire op_branch = code == operation_code_lines_pkg::OP_BRANCH;
    wire op_dread = code == operation_code_lines_pkg::OP_DREAD;
    wire op_restore = code == operation_code_lines_pkg::OP_RESTORE;
    wire op_dwrite = code == operation_code_lines_pkg::OP_DWRITE;
    wire op_dc_hi = code == operation_code_lines_pkg::OP_DC_HI;
    wire op_pcb_hi = code == operation_code_lines_pkg::OP_PCB_HI;
    wire op_call0 = code == operation_code_lines_pkg::OP_CALL0;
    wire op_dc_lo = code == operation_code_lines_pkg::OP_DC_LO;
    // Address range match against local counters
    wire [15:0] pc_off = pc_reg - BASE_ADDR;
    wire [15:0] dc_off = dc_reg - BASE_ADDR;
    wire pc_hit = (pc_reg >= BASE_ADDR) && ((pc_off >> MEM_ABITS) == 16'h0000);
    wire dc_hit = (dc_reg >= BASE_ADDR) && ((dc_off >> MEM_ABITS) == 16'h0000);
    wire use_dc = op_dread || op_dwrite;
    wire [MEM_ABITS-1:0] rd_addr = use_dc ? dc_off[MEM_ABITS-1:0] : pc_off[MEM_ABITS-1:0];
    wire mem_we = cycle_end && op_dwrite && dc_hit;
    wire [15:0] branch_off = {{(operation_code_lines_pkg::ADDR_W - operation_code_lines_pkg::DATA_W){bus_value[operation_code_lines_pkg::SIGN_BIT]}}, bus_value};

    operation_code_lines_mem #(.ABITS(MEM_ABITS)) u_operation_code_lines_mem (
        .clk(clk),
        .raddr(rd_addr),
        .rdata(mem_rdata),
        .we(mem_we),
        .waddr(dc_off[MEM_ABITS-1:0]),
        .wdata(bus_value)
    );

    // Bus drive selection within a cycle
    always_comb begin
        drive_next = 8'h00;
        oe_next = 1'b0;
        if (in_cycle) begin
            if ((op_fetch || op_branch) && pc_hit) begin
                drive_next = mem_rdata;
                oe_next = 1'b1;
            end else if (op_dread && dc_hit) begin
                drive_next = mem_rdata;
                oe_next = 1'b1;
            end else if (op_dc_hi && dc_hit) begin
                drive_next = dc_reg[15:operation_code_lines_pkg::HI_LSB];
                oe_next = 1'b1;
            end else if (op_pcb_hi && pc_hit) begin
                drive_next = pcb_reg[15:operation_code_lines_pkg::HI_LSB];
                oe_next = 1'b1;
            end else if (op_dc_lo && dc_hit) begin
                drive_next = dc_reg[operation_code_lines_pkg::HI_LSB-1:0];
                oe_next = 1'b1;
            end
        end
    end

    // Counter updates applied by every device at cycle end
    always_comb begin
        pc_next = pc_reg;
        pcb_next = pcb_reg;
        dc_next = dc_reg;
        if (cycle_end) begin
            if (op_fetch) begin
                pc_next = pc_reg + operation_code_lines_pkg::ONE16;
            end else if (op_branch) begin
                pc_next = pc_reg + branch_off;
            end else if (op_dread || op_dwrite) begin
                dc_next = dc_reg + operation_code_lines_pkg::ONE16;
            end else if (op_restore) begin
                pc_next = pcb_reg;
            end else if (op_call0) begin
                pcb_next = pc_reg;
                pc_next = {bus_value, bus_value};
            end
        end
    end

    // All state on the processor clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_reg <= operation_code_lines_pkg::PC_RESET;
            pcb_reg <= operation_code_lines_pkg::PC_RESET;
            dc_reg <= operation_code_lines_pkg::DC_RESET;
            strobe_q <= 1'b1;
            drive_reg <= 8'h00;
            oe_reg <= 1'b0;
        end else begin
            pc_reg <= pc_next;
            pcb_reg <= pcb_next;
            dc_reg <= dc_next;
            strobe_q <= cycle_strobe;
            drive_reg <= drive_next;
            oe_reg <= oe_next;
        end
    end

    assign bus_drive = drive_reg;
    assign db_oe = oe_reg;
    assign program_counter = pc_reg;
    assign program_counter_backup = pcb_reg;
    assign data_counter = dc_reg;

    property p_fetch_inc;
        @(posedge clk) disable iff (!rst_n)
        (cycle_end && op_fetch) |=> (pc_reg == $past(pc_reg) + operation_code_lines_pkg::ONE16);
    endproperty
    a_fetch_inc: assert property (p_fetch_inc) else $error("pc not incremented");

    property p_restore;
        @(posedge clk) disable iff (!rst_n)
        (cycle_end && op_restore) |=> (pc_reg == $past(pcb_reg));
    endproperty
    a_restore: assert property (p_restore) else $error("pc not restored");

    property p_dread_inc;
        @(posedge clk) disable iff (!rst_n)
        (cycle_end && (op_dread || op_dwrite)) |=> (dc_reg == $past(dc_reg) + operation_code_lines_pkg::ONE16);
    endproperty
    a_dread_inc: assert property (p_dread_inc) else $error("dc not incremented");

    property p_call0;
        @(posedge clk) disable iff (!rst_n)
        (cycle_end && op_call0) |=> (pcb_reg == $past(pc_reg)) && (pc_reg == {2{$past(bus_value)}});
    endproperty
    a_call0: assert property (p_call0) else $error("call0 mismatch");

    property p_hold;
        @(posedge clk) disable iff (!rst_n)
        !cycle_end |=> $stable(pc_reg) && $stable(dc_reg) && $stable(pcb_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("counter moved mid cycle");

    property p_range;
        @(posedge clk) disable iff (!rst_n)
        (in_cycle && (op_fetch || op_branch) && !pc_hit) |=> !db_oe;
    endproperty
    a_range: assert property (p_range) else $error("drove bus out of range");

    property p_dc_lo;
        @(posedge clk) disable iff (!rst_n)
        (in_cycle && op_dc_lo && dc_hit) |=> db_oe && (bus_drive == $past(dc_reg[operation_code_lines_pkg::HI_LSB-1:0]));
    endproperty
    a_dc_lo: assert property (p_dc_lo) else $error("dc low byte wrong");

    property p_branch;
        @(posedge clk) disable iff (!rst_n)
        (cycle_end && op_branch) |=> (pc_reg == $past(pc_reg) + $past(branch_off));
    endproperty
    a_branch: assert property (p_branch) else $error("branch add wrong");

    property p_ignored_code;
        @(posedge clk) disable iff (!rst_n)
        (cycle_end && (code > operation_code_lines_pkg::OP_DC_LO)) |=> $stable(pc_reg) && $stable(pcb_reg) && $stable(dc_reg);
    endproperty
    a_ignored_code: assert property (p_ignored_code) else $error("ignored code moved a counter");

    property p_dc_hi;
        @(posedge clk) disable iff (!rst_n)
        (in_cycle && op_dc_hi && dc_hit) |=> db_oe && (bus_drive == $past(dc_reg[15:operation_code_lines_pkg::HI_LSB]));
    endproperty
    a_dc_hi: assert property (p_dc_hi) else $error("dc high byte wrong");

    property p_pcb_hi;
        @(posedge clk) disable iff (!rst_n)
        (in_cycle && op_pcb_hi && pc_hit) |=> db_oe && (bus_drive == $past(pcb_reg[15:operation_code_lines_pkg::HI_LSB]));
    endproperty
    a_pcb_hi: assert property (p_pcb_hi) else $error("backup pc high byte wrong");

    property p_dwrite_quiet;
        @(posedge clk) disable iff (!rst_n)
        (in_cycle && op_dwrite) |=> !db_oe;
    endproperty
    a_dwrite_quiet: assert property (p_dwrite_quiet) else $error("drove bus during a store");
endmodule : operation_code_lines_responder

/* operation_code_lines_cpu_model.sv */
// Processor model driving strobe, operation code and its bus byte
module operation_code_lines_cpu_model (
    // Clock
    input wire logic clk,
    // Control to responders
    output logic cycle_strobe,
    output logic [4:0] operation_code_lines,
    // Bus
    output logic [7:0] cpu_db,
    input wire logic [7:0] bus,
    input wire logic bus_oe,
    output logic [7:0] seen_db,
    output logic seen_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cycle_strobe = 1'b1;
        operation_code_lines = 5'h1F;
        cpu_db = 8'h00;
        seen_db = 8'h00;
        seen_oe = 1'b0;
    end
    // One cycle of four or six clocks, strobe high only in the last
    task automatic run(input logic [4:0] code, input bit lng, input logic [7:0] data, input bit drv);
        @(negedge clk);
        cycle_strobe = 1'b0;
        operation_code_lines = code;
        cpu_db = drv ? data : ~cpu_db;
        repeat (lng ? 5 : 3) @(negedge clk);
        seen_db = bus;
        seen_oe = bus_oe;
        cycle_strobe = 1'b1;
    endtask : run
endmodule : operation_code_lines_cpu_model

/* tb.sv */
// Testbench for the operation code responder
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cycle_strobe, db_oe, seen_oe;
    logic [4:0] operation_code_lines;
    logic [7:0] cpu_db, db_out, seen_db;
    logic [15:0] pc, pcb, dc;
    wire logic [7:0] bus = db_oe ? db_out : cpu_db;
    int bad_count = 0;
    int n_checks = 0;
    always #10 clk = ~clk;
    operation_code_lines_responder #(.MEM_ABITS(4), .BASE_ADDR(16'h0000)) u_operation_code_lines_responder (.clk(clk), .rst_n(rst_n),
        .cycle_strobe(cycle_strobe), .operation_code_lines(operation_code_lines), .bus_value(bus),
        .bus_drive(db_out), .db_oe(db_oe), .program_counter(pc), .program_counter_backup(pcb), .data_counter(dc));
    operation_code_lines_cpu_model u_operation_code_lines_cpu_model (.clk(clk), .cycle_strobe(cycle_strobe),
        .operation_code_lines(operation_code_lines), .cpu_db(cpu_db), .bus(bus), .bus_oe(db_oe),
        .seen_db(seen_db), .seen_oe(seen_oe));
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: counter %h expected %h", $time, got, exp);
        end
    endtask : chk16
    task automatic chk_bus(input logic oe, input logic [7:0] d);
        n_checks++;
        if (seen_oe !== oe || (oe && seen_db !== d)) begin
            bad_count++;
            $display("wrong value at %0t: bus %b/%h expected %b/%h", $time, seen_oe, seen_db, oe, d);
        end
    endtask : chk_bus
    // One cycle, then let the closing edge land
    task automatic cyc(input logic [4:0] c, input bit l, input logic [7:0] d, input bit dr);
        u_operation_code_lines_cpu_model.run(c, l, d, dr);
        @(posedge clk);
        #1;
    endtask : cyc
    function automatic logic [7:0] pat(input int i);
        return (i == 2) ? 8'hFE : 8'h50 + 8'(i);
    endfunction : pat
    task automatic t_write;
        for (int i = 0; i < 16; i++) begin
            cyc(5'h05, 1, pat(i), 1);
            chk_bus(1'b0, 8'h00);
            chk16(dc, 16'(i + 1));
        end
        cyc(5'h09, 1, 8'h00, 0);
        chk_bus(1'b0, 8'h00);
        cyc(5'h02, 1, 8'h00, 0);
        chk_bus(1'b0, 8'h00);
        chk16(dc, 16'h0011);
        cyc(5'h05, 1, 8'h77, 1);
        chk_bus(1'b0, 8'h00);
        chk16(dc, 16'h0012);
        $display("test write done");
    endtask : t_write
    task automatic t_fetch;
        @(negedge clk);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        chk16(dc, 16'h0000);
        cyc(5'h00, 0, 8'h00, 0);
        chk_bus(1'b1, pat(0));
        chk16(pc, 16'h0001);
        cyc(5'h03, 1, 8'h00, 0);
        chk_bus(1'b1, pat(1));
        chk16(pc, 16'h0002);
        cyc(5'h01, 1, 8'h00, 0);
        chk_bus(1'b1, 8'hFE);
        chk16(pc, 16'h0000);
        cyc(5'h02, 1, 8'h00, 0);
        chk_bus(1'b1, pat(0));
        chk16(dc, 16'h0001);
        cyc(5'h09, 1, 8'h00, 0);
        chk_bus(1'b1, 8'h01);
        cyc(5'h06, 1, 8'h00, 0);
        chk_bus(1'b1, 8'h00);
        $display("test fetch done");
    endtask : t_fetch
    task automatic t_call;
        cyc(5'h00, 1, 8'h00, 0);
        cyc(5'h08, 1, 8'h00, 1);
        chk16(pc, 16'h0000);
        chk16(pcb, 16'h0001);
        cyc(5'h07, 1, 8'h00, 0);
        chk_bus(1'b1, 8'h00);
        cyc(5'h00, 0, 8'h00, 0);
        cyc(5'h00, 0, 8'h00, 0);
        cyc(5'h04, 0, 8'h00, 0);
        chk16(pc, 16'h0001);
        for (int c = 10; c < 32; c++) begin
            cyc(5'(c), 0, 8'hA5, 1);
            chk_bus(1'b0, 8'h00);
        end
        chk16(pc, 16'h0001);
        chk16(dc, 16'h0001);
        cyc(5'h01, 1, 8'h00, 0);
        chk_bus(1'b1, pat(1));
        chk16(pc, 16'h0052);
        cyc(5'h00, 0, 8'h00, 0);
        chk_bus(1'b0, 8'h00);
        chk16(pc, 16'h0053);
        $display("test call done");
    endtask : t_call
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        chk16(pc, 16'h0000);
        chk16(pcb, 16'h0000);
        t_write();
        t_fetch();
        t_call();
        report_and_stop();
    end
    // About 290 clocks expected; 5000 clocks is a hang
    initial begin
        #100000;
        bad_count++;
        report_and_stop();
    end
endmodule : tb
